// ---- core/gbt_pkg.sv ----
// Constants for the group base timer: register map, field positions, resets.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit counter.
package gbt_pkg;

  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_IFS       = 8'h04;
  localparam logic [7:0]  ADDR_CMP       = 8'h08;
  localparam logic [7:0]  ADDR_CNT       = 8'h0c;

  localparam int          RUN_BIT        = 0;
  localparam int          MATCH_RST_BIT  = 1;
  localparam int          EXT_RST_BIT    = 2;
  localparam int          STYLE_LO_BIT   = 5;
  localparam int          STYLE_HI_BIT   = 6;
  localparam int          CNT_DOWN_BIT   = 16;

  localparam int          G0_SEL_LO_BIT  = 22;
  localparam int          G0_SEL_HI_BIT  = 23;
  localparam int          G1_SEL_LO_BIT  = 26;
  localparam int          G1_SEL_HI_BIT  = 27;

  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] IFS_RST        = 32'h0000_0000;
  localparam logic [15:0] CMP_RST        = 16'h0000;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam logic [15:0] CNT_TOP        = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM     = 16'h0000;
  localparam logic [1:0]  MATCH_LAG      = 2'h2;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Order matches the two style bits: 00, 01, 10, 11
  typedef enum logic [1:0] {
    GBT_INC,
    GBT_UPDOWN,
    GBT_TWO_PHASE,
    GBT_FORBIDDEN
  } gbt_style_e;

endpackage

// ---- core/gbt_ctl_if.sv ----
// Carrier between the register block and the counter core.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface gbt_ctl_if;
  import gbt_pkg::*;
  logic        run;
  logic        match_rst;
  logic        ext_rst;
  gbt_style_e  style;
  logic [15:0] compare;
  logic [15:0] count;
  logic        down;

  modport ctl (output run, output match_rst, output ext_rst, output style, output compare,
               input count, input down);
  modport tmr (input run, input match_rst, input ext_rst, input style, input compare,
               output count, output down);
endinterface

// ---- core/gbt_counter.sv ----
// Counter core: 16-bit base timer with increment, up/down and two-phase styles.
// Assumes phase inputs are synchronous to i_clk; at most one count per clock when running.
`timescale 1ns/1ps
module gbt_counter
  import gbt_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_phase_a,
  input  wire logic i_phase_b,
  gbt_ctl_if.tmr    bus
);
  import gbt_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        down;
    logic [1:0]  lag;
    logic        ph_a;
    logic        ph_b;
  } gbt_cnt_s;

  gbt_cnt_s q;
  gbt_cnt_s d;
  logic     at_match;

  assign at_match  = bus.match_rst && (q.cnt == bus.compare);
  assign bus.count = q.cnt;
  assign bus.down  = q.down;

  always_comb begin
    d      = q;
    d.ph_a = i_phase_a;
    d.ph_b = i_phase_b;
    if (bus.ext_rst) begin
      d.cnt  = CNT_RST;
      d.down = 1'b0;
      d.lag  = 2'h0;
    end else if (bus.run) begin
      case (bus.style)
        GBT_INC: begin
          d.cnt = at_match ? CNT_RST : q.cnt + 16'h1;
        end
        GBT_UPDOWN: begin
          if (q.down) begin
            d.cnt = q.cnt - 16'h1;
            d.lag = 2'h0;
            if (d.cnt == CNT_BOTTOM) begin
              d.down = 1'b0;
            end
          end else if (q.lag == 2'h1) begin
            d.cnt  = q.cnt - 16'h1;
            d.down = 1'b1;
            d.lag  = 2'h0;
          end else begin
            d.cnt = q.cnt + 16'h1;
            if (q.lag != 2'h0) begin
              d.lag = q.lag - 2'h1;
            end else if (at_match) begin
              d.lag = MATCH_LAG;
            end
            if (d.cnt == CNT_TOP) begin
              d.down = 1'b1;
            end
          end
        end
        GBT_TWO_PHASE: begin
          if ((i_phase_a ^ q.ph_a) || (i_phase_b ^ q.ph_b)) begin
            d.cnt = (i_phase_a ^ q.ph_b) ? q.cnt + 16'h1 : q.cnt - 16'h1;
          end
        end
        default: begin
          // Forbidden style: hold rather than guess a direction
          d.cnt = q.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_ext_reset_clears: assert property (bus.ext_rst |=> q.cnt == CNT_RST && !q.down)
    else $error("ext pin reset did not clear counter");
  chk_stop_holds: assert property (!bus.run && !bus.ext_rst |=> $stable(q.cnt))
    else $error("counter moved while stopped");
  chk_inc_counts: assert property (bus.run && bus.style == GBT_INC && !bus.ext_rst && !at_match
    |=> q.cnt == $past(q.cnt) + 16'h1)
    else $error("increment mode did not count");
  chk_top_turns: assert property (bus.run && bus.style == GBT_UPDOWN && !bus.ext_rst && !q.down
    && q.lag != 2'h1 && q.cnt == 16'hfffe |=> q.down && q.cnt == CNT_TOP)
    else $error("no turn to down at top");
  chk_bottom_turns: assert property (bus.run && bus.style == GBT_UPDOWN && !bus.ext_rst && q.down
    && q.cnt == 16'h0001 |=> !q.down && q.cnt == CNT_BOTTOM)
    else $error("no turn to up at zero");
  chk_match_lag: assert property ((bus.run && bus.style == GBT_UPDOWN && !bus.ext_rst && !q.down
    && q.lag == 2'h0 && at_match) ##1 (bus.run && bus.style == GBT_UPDOWN && !bus.ext_rst)[*2]
    |=> q.down && q.cnt == $past(q.cnt) - 16'h1)
    else $error("match did not turn down two counts later");
  chk_two_phase_up: assert property (bus.run && bus.style == GBT_TWO_PHASE && !bus.ext_rst
    && (i_phase_a ^ q.ph_a) && (i_phase_a ^ q.ph_b) |=> q.cnt == $past(q.cnt) + 16'h1)
    else $error("two-phase edge did not count up");
  chk_forbidden_holds: assert property (bus.style == GBT_FORBIDDEN && !bus.ext_rst
    |=> $stable(q.cnt))
    else $error("forbidden style moved counter");

  cov_turn_down: cover property (bus.style == GBT_UPDOWN && $rose(q.down));
  cov_turn_up: cover property (bus.style == GBT_UPDOWN && $fell(q.down));
  cov_ext_reset: cover property (bus.ext_rst && q.cnt != CNT_RST);

endmodule

// ---- core/gbt_top.sv ----
// Group base timer: AXI4-Lite register slave, reset pin select, counter core.
// Assumes AXI4-Lite master on i_clk; external pins already synchronous.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module gbt_top
  import gbt_pkg::*;
#(
  parameter bit P_GROUP = 1'b0
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  input  wire logic [gbt_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                   i_s_axi_awvalid,
  output      logic                   o_s_axi_awready,
  input  wire logic [31:0]            i_s_axi_wdata,
  input  wire logic [3:0]             i_s_axi_wstrb,
  input  wire logic                   i_s_axi_wvalid,
  output      logic                   o_s_axi_wready,
  output      logic [1:0]             o_s_axi_bresp,
  output      logic                   o_s_axi_bvalid,
  input  wire logic                   i_s_axi_bready,
  input  wire logic [gbt_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                   i_s_axi_arvalid,
  output      logic                   o_s_axi_arready,
  output      logic [31:0]            o_s_axi_rdata,
  output      logic [1:0]             o_s_axi_rresp,
  output      logic                   o_s_axi_rvalid,
  input  wire logic                   i_s_axi_rready,
  input  wire logic                   i_ext_irq_pin_a,
  input  wire logic                   i_ext_irq_pin_b,
  input  wire logic                   i_phase_a,
  input  wire logic                   i_phase_b,
  output      logic [15:0]            o_count,
  output      logic                   o_count_down
);
  import gbt_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              aw_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              w_have;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       ctrl;
    logic [31:0]       ifs;
    logic [15:0]       cmp;
  } gbt_regs_s;

  gbt_regs_s q;
  gbt_regs_s d;
  logic [1:0] pin_sel;
  logic       pin_low;

  gbt_ctl_if ctl ();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // 00 picks pin a, 01 picks pin b; upper codes leave this source idle
  assign pin_sel = P_GROUP ? q.ifs[G1_SEL_HI_BIT:G1_SEL_LO_BIT]
                           : q.ifs[G0_SEL_HI_BIT:G0_SEL_LO_BIT];
  always_comb begin
    if (pin_sel == 2'h0) begin
      pin_low = !i_ext_irq_pin_a;
    end else if (pin_sel == 2'h1) begin
      pin_low = !i_ext_irq_pin_b;
    end else begin
      pin_low = 1'b0;
    end
  end

  assign ctl.ext_rst   = q.ctrl[EXT_RST_BIT] && pin_low;
  assign ctl.run       = q.ctrl[RUN_BIT];
  assign ctl.match_rst = q.ctrl[MATCH_RST_BIT];
  assign ctl.style     = gbt_style_e'(q.ctrl[STYLE_HI_BIT:STYLE_LO_BIT]);
  assign ctl.compare   = q.cmp;

  // One write in flight: both readies drop while the response waits, so no beat is lost
  assign o_s_axi_awready = !q.aw_have && !q.bvalid;
  assign o_s_axi_wready  = !q.w_have && !q.bvalid;
  assign o_s_axi_arready = !q.rvalid;
  assign o_s_axi_bvalid  = q.bvalid;
  assign o_s_axi_bresp   = q.bresp;
  assign o_s_axi_rvalid  = q.rvalid;
  assign o_s_axi_rdata   = q.rdata;
  assign o_s_axi_rresp   = q.rresp;
  assign o_count         = ctl.count;
  assign o_count_down    = ctl.down;

  always_comb begin
    d = q;
    if (q.bvalid && i_s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && i_s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata  = i_s_axi_wdata;
      d.wstrb  = i_s_axi_wstrb;
    end
    if (d.aw_have && d.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (d.awaddr == ADDR_CTRL) begin
        d.ctrl = merge(q.ctrl, d.wdata, d.wstrb);
      end else if (d.awaddr == ADDR_IFS) begin
        d.ifs = merge(q.ifs, d.wdata, d.wstrb);
      end else if (d.awaddr == ADDR_CMP) begin
        d.cmp = 16'(merge({16'h0, q.cmp}, d.wdata, d.wstrb));
      end else if (d.awaddr == ADDR_CNT) begin
        // Counter is read-only; the write is accepted and dropped
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (i_s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      if (i_s_axi_araddr == ADDR_CTRL) begin
        d.rdata = q.ctrl;
      end else if (i_s_axi_araddr == ADDR_IFS) begin
        d.rdata = q.ifs;
      end else if (i_s_axi_araddr == ADDR_CMP) begin
        d.rdata = {16'h0, q.cmp};
      end else if (i_s_axi_araddr == ADDR_CNT) begin
        d.rdata = {15'h0, ctl.down, ctl.count};
      end else begin
        d.rdata = 32'h0;
        d.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q      <= '0;
      q.ctrl <= CTRL_RST;
      q.ifs  <= IFS_RST;
      q.cmp  <= CMP_RST;
    end else begin
      q <= d;
    end
  end

  gbt_counter u_counter (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_phase_a (i_phase_a),
    .i_phase_b (i_phase_b),
    .bus       (ctl)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_pin_a_reset: assert property (q.ctrl[EXT_RST_BIT] && pin_sel == 2'h0 && !i_ext_irq_pin_a
    |=> o_count == CNT_RST)
    else $error("pin a low did not reset counter");
  chk_ext_disabled: assert property (!q.ctrl[EXT_RST_BIT] |-> !ctl.ext_rst)
    else $error("ext reset active while disabled");
  chk_write_resp: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
    && o_s_axi_wready |=> o_s_axi_bvalid)
    else $error("write response missing");
  chk_read_resp: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read response missing");

  // Pin b resets the timer just as pin a does; upper select codes leave the source idle
  chk_pin_b_reset: assert property (q.ctrl[EXT_RST_BIT] && pin_sel == 2'h1 && !i_ext_irq_pin_b
    |=> o_count == CNT_RST)
    else $error("pin b low did not reset counter");
  chk_idle_select: assert property (pin_sel[1] |-> !ctl.ext_rst)
    else $error("ext reset active with no pin selected");
  // Register effects are checked in the compare register and at the bus, so a decode slip shows even while the timer idles
  chk_cmp_write: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    && i_s_axi_awaddr == ADDR_CMP && i_s_axi_wstrb == 4'hf |=> q.cmp == $past(i_s_axi_wdata[15:0]))
    else $error("compare write did not land");
  chk_unmapped_err: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    && i_s_axi_awaddr != ADDR_CTRL && i_s_axi_awaddr != ADDR_IFS && i_s_axi_awaddr != ADDR_CMP
    && i_s_axi_awaddr != ADDR_CNT |=> o_s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_count_read: assert property (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == ADDR_CNT
    |=> o_s_axi_rdata == {15'h0, $past(o_count_down), $past(o_count)})
    else $error("count read did not return the timer");

  cov_axi_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
  cov_pin_b_reset: cover property (ctl.ext_rst && pin_sel == 2'h1);

endmodule

// ---- test/gbt_pin_model.sv ----
// Far-side model: active-low external interrupt pins and a two-phase encoder.
// Assumes requests come from the bench on i_clk; both pins have pull-ups.
`timescale 1ns/1ps
module gbt_pin_model (
  input  wire logic i_clk,
  input  wire logic i_low_a,
  input  wire logic i_low_b,
  input  wire logic i_step_up,
  input  wire logic i_step_dn,
  output      logic o_pin_a,
  output      logic o_pin_b,
  output      logic o_phase_a,
  output      logic o_phase_b
);
  logic [1:0] idx_q = 2'h0;

  // Released pins float back to the pull-up level
  assign o_pin_a = !i_low_a;
  assign o_pin_b = !i_low_b;
  // Order 00,10,11,01 counts up; one phase edge per step so no step is lost
  assign o_phase_a = idx_q[1] ^ idx_q[0];
  assign o_phase_b = idx_q[1];

  always @(posedge i_clk) begin
    if (i_step_up) idx_q <= idx_q + 2'h1;
    else if (i_step_dn) idx_q <= idx_q - 2'h1;
  end
endmodule

// ---- test/group_base_timer_tb.sv ----
// Self-checking bench for the group base timer.
// Assumes an AXI4-Lite master here and the pin model on the far side.
`timescale 1ns/1ps
module group_base_timer_tb;
  import gbt_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] br; logic [31:0] rv; logic [1:0] rr;} gbt_row_s;
  typedef struct packed {logic [31:0] ext; logic [31:0] ifs; logic pin; logic clr;} gbt_pin_s;
  logic        i_clk = 1'b0, i_reset = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, st, c0, s;
  logic        awready, wready, bvalid, arready, rvalid, cnt_down, pin_a, pin_b, ph_a, ph_b;
  logic [1:0]  bresp, rresp;
  logic [15:0] cnt;
  logic        low_a = 1'b0, low_b = 1'b0, st_up = 1'b0, st_dn = 1'b0;
  int          errors = 0, total_checks = 0;
  gbt_row_s rows [5] = '{
    '{ADDR_CTRL, 32'h0000_0046, RESP_OKAY, 32'h0000_0046, RESP_OKAY},
    '{ADDR_IFS, 32'h0cc0_0000, RESP_OKAY, 32'h0cc0_0000, RESP_OKAY},
    '{ADDR_CMP, 32'h0000_1234, RESP_OKAY, 32'h0000_1234, RESP_OKAY},
    '{ADDR_CNT, 32'h0000_ffff, RESP_OKAY, 32'h0000_0000, RESP_OKAY},
    '{8'h10, 32'h0000_0001, RESP_SLVERR, 32'h0000_0000, RESP_SLVERR}};
  gbt_pin_s pins [6] = '{
    '{32'h0, 32'h0, 1'b0, 1'b0}, '{32'h4, 32'h0, 1'b1, 1'b0}, '{32'h4, 32'h0, 1'b0, 1'b1},
    '{32'h4, 32'h0040_0000, 1'b1, 1'b1}, '{32'h4, 32'h0080_0000, 1'b0, 1'b0},
    '{32'h4, 32'h0800_0000, 1'b0, 1'b1}};

  always #10 i_clk = ~i_clk;
  assign st = {15'h0, cnt_down, cnt};

  gbt_top #(.P_GROUP(1'b0)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_ext_irq_pin_a(pin_a), .i_ext_irq_pin_b(pin_b), .i_phase_a(ph_a), .i_phase_b(ph_b),
    .o_count(cnt), .o_count_down(cnt_down));

  gbt_pin_model u_pins (
    .i_clk(i_clk), .i_low_a(low_a), .i_low_b(low_b), .i_step_up(st_up), .i_step_dn(st_dn),
    .o_pin_a(pin_a), .o_pin_b(pin_b), .o_phase_a(ph_a), .o_phase_b(ph_b));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_r(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge i_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    while (!done) begin
      @(negedge i_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      if (done) cmp_r(bresp, er);
      @(posedge i_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic tk, done;
    done = 1'b0;
    @(posedge i_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done) begin
      @(negedge i_clk);
      tk = arvalid && arready;
      done = rvalid;
      if (done) cmp(rdata, ed);
      if (done) cmp_r(rresp, er);
      @(posedge i_clk);
      if (tk) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  // Holds the pin low for two edges and samples the state after the first
  task automatic pulse(input logic b, output logic [31:0] v);
    @(posedge i_clk);
    if (b) low_b <= 1'b1;
    else low_a <= 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    v = st;
    @(posedge i_clk);
    low_a <= 1'b0;
    low_b <= 1'b0;
  endtask

  task automatic step(input logic dn, input logic [31:0] ev);
    @(posedge i_clk);
    st_up <= !dn;
    st_dn <= dn;
    @(posedge i_clk);
    st_up <= 1'b0;
    st_dn <= 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    cmp(st & 32'hffff, ev);
  endtask

  // Bounded wait; a timeout shows up as a value mismatch
  task automatic wait_st(input logic [31:0] v, input int lim);
    int n;
    n = 0;
    @(negedge i_clk);
    while (st !== v && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    cmp(st, v);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge i_clk);
    errors++;
    results();
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(8'(4 * i), 32'h0, RESP_OKAY);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].br);
      rdc(rows[i].a, rows[i].rv, rows[i].rr);
    end
    // Increment mode runs, then holds once stopped
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    @(negedge i_clk);
    c0 = st;
    @(negedge i_clk);
    cmp(st, c0 + 32'h1);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    @(negedge i_clk);
    c0 = st;
    repeat (5) @(negedge i_clk);
    cmp(st, c0);
    foreach (pins[i]) begin
      wr(ADDR_IFS, pins[i].ifs, RESP_OKAY);
      wr(ADDR_CTRL, pins[i].ext | 32'h1, RESP_OKAY);
      wr(ADDR_CTRL, pins[i].ext, RESP_OKAY);
      @(negedge i_clk);
      c0 = st;
      pulse(pins[i].pin, s);
      cmp(s, pins[i].clr ? 32'h0 : c0);
    end
    // Two-phase mode follows the encoder both ways
    // Style code 11 is never written: every control word keeps bits 6:5 off 11
    wr(ADDR_CTRL, 32'h41, RESP_OKAY);
    @(negedge i_clk);
    c0 = st & 32'hffff;
    for (int i = 1; i <= 3; i++) step(1'b0, c0 + 32'(i));
    step(1'b1, c0 + 32'h2);
    step(1'b1, c0 + 32'h1);
    // Compare match turns the count down two counts later
    wr(ADDR_CMP, 32'h8, RESP_OKAY);
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    pulse(1'b0, s);
    cmp(s, 32'h0);
    wr(ADDR_CTRL, 32'h27, RESP_OKAY);
    wait_st(32'h0000_0008, 100);
    @(negedge i_clk);
    cmp(st, 32'h0000_0009);
    @(negedge i_clk);
    cmp(st, 32'h0000_000a);
    @(negedge i_clk);
    cmp(st, 32'h0001_0009);
    wait_st(32'h0001_0001, 100);
    @(negedge i_clk);
    cmp(st, 32'h0000_0000);
    @(negedge i_clk);
    cmp(st, 32'h0000_0001);
    // Full up/down sweep to the top value
    wr(ADDR_CTRL, 32'h25, RESP_OKAY);
    wait_st(32'h0000_fffe, 70000);
    @(negedge i_clk);
    cmp(st, 32'h0001_ffff);
    @(negedge i_clk);
    cmp(st, 32'h0001_fffe);
    pulse(1'b0, s);
    cmp(s, 32'h0);
    // Reset in mid-run clears the count and the registers, even while counting
    wr(ADDR_CTRL, 32'h21, RESP_OKAY);
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    cmp(st, 32'h0);
    repeat (3) @(negedge i_clk);
    cmp(st, 32'h0);
    rdc(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    results();
  end
endmodule
